// *** rtl/tbc_pkg.sv ***
// Package for the converter base configuration block: map, layouts, timing
package tbc_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0]  ADR_CFG         = 4'h0;
    localparam logic [3:0]  ADR_EXT         = 4'h4;
    localparam logic [3:0]  ADR_STAT        = 4'h8;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    localparam logic        EXT_RESET       = 1'b0;
    localparam int          EXT_OSC_MSB_BIT = 20;
    localparam int          BYTE_W          = 8;
    localparam int          NUM_LANES       = 4;
    localparam int          NUM_EDGES       = 3;

    // Oscillator start codes
    localparam logic [2:0]  OSC_CODE_OFF    = 3'h0;
    localparam logic [2:0]  OSC_CODE_ON     = 3'h1;
    localparam logic [2:0]  OSC_CODE_S480   = 3'h2;
    localparam logic [2:0]  OSC_CODE_S1460  = 3'h3;
    localparam logic [2:0]  OSC_CODE_S2440  = 3'h4;

    // Clock and settling times
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          SETTLE_A_NS     = 480000;
    localparam int          SETTLE_B_NS     = 1460000;
    localparam int          SETTLE_C_NS     = 2440000;
    localparam int          SETTLE_D_NS     = 5140000;
    localparam int          SETTLE_A_CYC    = (SETTLE_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_B_CYC    = (SETTLE_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_C_CYC    = (SETTLE_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_D_CYC    = (SETTLE_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TMR_W           = 21;

    // Temperature times in ticks of the fast reference clock; dummy, port and calibration counts, the last in slow clock periods
    localparam int          FAST_CLK_MHZ    = 4;
    localparam int          TEMP_SHORT_US   = 128;
    localparam int          TEMP_LONG_US    = 512;
    localparam logic [TMR_W-1:0] TEMP_SHORT_TICKS = TMR_W'(TEMP_SHORT_US * FAST_CLK_MHZ);
    localparam logic [TMR_W-1:0] TEMP_LONG_TICKS  = TMR_W'(TEMP_LONG_US * FAST_CLK_MHZ);
    localparam logic [6:0]  CYCLE_DIV_LAST  = 7'h7f;
    localparam logic [3:0]  DUMMY_FEW       = 4'h2;
    localparam logic [3:0]  DUMMY_MANY      = 4'h7;
    localparam logic [3:0]  PORTS_FEW       = 4'h2;
    localparam logic [3:0]  PORTS_MANY      = 4'h4;
    localparam logic [TMR_W-1:0] CAL_BASE_PERIODS = 21'h000002;

    // Configuration word layout, most significant field first
    typedef struct packed {
        logic [7:0] fire_bits;
        logic [1:0] resonator_cal_periods;
        logic [1:0] fast_clock_predivider;
        logic [1:0] oscillator_start_code;
        logic       temp_port_count;
        logic       temp_cycle_time;
        logic       temp_dummy_cycles;
        logic       temp_cycle_clock_source;
        logic       alu_calibrate;
        logic       auto_cal_disable;
        logic       second_mode_select;
        logic       stop_b_polarity;
        logic       stop_a_polarity;
        logic       start_polarity;
        logic [7:0] user_tag_bits;
    } tbc_cfg_t;

    // Status word layout
    typedef struct packed {
        logic [23:0] rsvd;
        logic        alu_cal_en;
        logic [1:0]  temp_port;
        logic        temp_dummy;
        logic        temp_active;
        logic        cal_busy;
        logic        osc_ready;
        logic        osc_en;
    } tbc_stat_t;

    // Wishbone request and answer
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tbc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } tbc_wb_rsp_t;
endpackage : tbc_pkg

// *** rtl/tbc_tick_timer.sv ***
// Loadable down counter that advances on a tick and pulses when it runs out
module tbc_tick_timer
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    load_i,
    input  wire logic [tbc_pkg::TMR_W-1:0] load_val_i,
    input  wire logic                    tick_i,
    output logic                         done_o
);
    import tbc_pkg::*;

    logic [TMR_W-1:0] cnt_r;
    logic             run_r;
    logic             last_w;

    assign last_w = run_r && tick_i && (cnt_r == TMR_W'(1));

    // Count down while running, a new load restarts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end
        else if (load_i)
        begin
            cnt_r <= load_val_i;
            run_r <= 1'b1;
        end
        else if (run_r && tick_i)
        begin
            cnt_r <= cnt_r - TMR_W'(1);
            run_r <= !last_w;
        end
    end

    // Expiry pulse, one cycle after the last tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done_o <= 1'b0;
        else
            done_o <= last_w && !load_i;
    end
endmodule : tbc_tick_timer

// *** rtl/tbc_base_config.sv ***
// Base configuration register and the measurement engine controls it steers
module tbc_base_config
#(
    parameter int unsigned SETTLE_A_CYC = tbc_pkg::SETTLE_A_CYC,
    parameter int unsigned SETTLE_B_CYC = tbc_pkg::SETTLE_B_CYC,
    parameter int unsigned SETTLE_C_CYC = tbc_pkg::SETTLE_C_CYC,
    parameter int unsigned SETTLE_D_CYC = tbc_pkg::SETTLE_D_CYC
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire tbc_pkg::tbc_wb_req_t wb_req_i,
    output tbc_pkg::tbc_wb_rsp_t      wb_rsp_o,
    input  wire logic                 fast_tick_i,
    input  wire logic                 slow_tick_i,
    input  wire logic                 meas_req_i,
    input  wire logic                 meas_done_i,
    input  wire logic                 cal_req_i,
    input  wire logic                 temp_req_i,
    input  wire logic                 start_i,
    input  wire logic                 stop_a_i,
    input  wire logic                 stop_b_i,
    output logic                      fast_div_tick_o,
    output logic                      osc_en_o,
    output logic                      osc_ready_o,
    output logic                      cal_busy_o,
    output logic                      auto_cal_o,
    output logic                      alu_cal_en_o,
    output logic                      second_mode_o,
    output logic [2:0]                edge_o,
    output logic                      temp_active_o,
    output logic                      temp_dummy_o,
    output logic [1:0]                temp_port_o,
    output logic                      temp_sample_o,
    output logic                      temp_done_o
);
    import tbc_pkg::*;

    typedef enum logic [2:0] {
        OSC_OFF    = 3'b001,
        OSC_SETTLE = 3'b010,
        OSC_ON     = 3'b100
    } tbc_osc_st_t;

    typedef enum logic [2:0] {
        TMP_IDLE = 3'b001,
        TMP_WAIT = 3'b010,
        TMP_RUN  = 3'b100
    } tbc_tmp_st_t;

    logic [31:0]      cfg_word_r;
    tbc_cfg_t         cfg;
    logic             ext_msb_r;
    logic             bus_req;
    logic             bus_wr;
    logic [31:0]      rd_nxt;
    tbc_stat_t        stat;
    logic [2:0]       osc_code;
    tbc_osc_st_t      osc_st_r;
    tbc_osc_st_t      osc_nxt;
    logic             settle_load;
    logic [TMR_W-1:0] settle_val;
    logic             settle_done;
    logic             cal_load;
    logic             cal_done;
    logic [1:0]       div_cnt_r;
    logic [1:0]       div_mask;
    logic [6:0]       cyc_cnt_r;
    logic             cycle_tick;
    tbc_tmp_st_t      tmp_st_r;
    tbc_tmp_st_t      tmp_nxt;
    logic [3:0]       idx_r;
    logic [3:0]       idx_nxt;
    logic [3:0]       dummy_r;
    logic [3:0]       ports_r;
    logic [3:0]       dummy_nxt;
    logic [3:0]       ports_nxt;
    logic             tmp_load;
    logic [TMR_W-1:0] tmp_load_val;
    logic             tmp_tmr_done;
    logic             sample_nxt;
    logic             done_nxt;
    logic [3:0]       port_idx;
    logic [2:0]       edge_in;
    logic [2:0]       edge_pol;
    logic [2:0]       edge_prev_r;

    assign cfg      = tbc_cfg_t'(cfg_word_r);
    assign bus_req  = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    // Write lands at the edge where the master samples ack, request still standing
    assign bus_wr   = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_rsp_o.ack;
    assign osc_code = {ext_msb_r, cfg.oscillator_start_code};

    // Configuration word, one flop group per byte lane; free bits just stored
    for (genvar b = 0; b < NUM_LANES; b++)
    begin : g_lane
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                cfg_word_r[b*BYTE_W +: BYTE_W] <= CFG_RESET[b*BYTE_W +: BYTE_W];
            else if (bus_wr && wb_req_i.adr == ADR_CFG && wb_req_i.sel[b])
                cfg_word_r[b*BYTE_W +: BYTE_W] <= wb_req_i.dat[b*BYTE_W +: BYTE_W];
        end
    end

    // Extended oscillator start bit, written by the host on its own lane
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ext_msb_r <= EXT_RESET;
        else if (bus_wr && wb_req_i.adr == ADR_EXT && wb_req_i.sel[EXT_OSC_MSB_BIT / BYTE_W])
            ext_msb_r <= wb_req_i.dat[EXT_OSC_MSB_BIT];
    end

    // Status word from the engine's own flops
    always_comb
    begin
        stat             = '0;
        stat.alu_cal_en  = alu_cal_en_o;
        stat.temp_port   = temp_port_o;
        stat.temp_dummy  = temp_dummy_o;
        stat.temp_active = temp_active_o;
        stat.cal_busy    = cal_busy_o;
        stat.osc_ready   = osc_ready_o;
        stat.osc_en      = osc_en_o;
    end

    // Read mux, unmapped offsets read zero
    always_comb
    begin
        rd_nxt = '0;
        case (wb_req_i.adr)
            ADR_CFG:  rd_nxt = cfg_word_r;
            ADR_EXT:  rd_nxt = 32'(ext_msb_r) << EXT_OSC_MSB_BIT;
            ADR_STAT: rd_nxt = stat;
            default:  rd_nxt = '0;
        endcase
    end

    // Bus answer one cycle after the request, then dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_rsp_o <= '0;
        else
        begin
            wb_rsp_o.ack <= bus_req;
            wb_rsp_o.dat <= bus_req ? rd_nxt : '0;
        end
    end

    // Fast clock predivider: codes 2 and 3 both divide by four
    always_comb
    begin
        case (cfg.fast_clock_predivider)
            2'h0:    div_mask = 2'h0;
            2'h1:    div_mask = 2'h1;
            default: div_mask = 2'h3;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_cnt_r       <= '0;
            fast_div_tick_o <= 1'b0;
        end
        else
        begin
            if (fast_tick_i)
                div_cnt_r <= div_cnt_r + 2'h1;
            fast_div_tick_o <= fast_tick_i && ((div_cnt_r & div_mask) == div_mask);
        end
    end

    // Settling time chosen by the full start code
    always_comb
    begin
        case (osc_code)
            OSC_CODE_S480:  settle_val = TMR_W'(SETTLE_A_CYC);
            OSC_CODE_S1460: settle_val = TMR_W'(SETTLE_B_CYC);
            OSC_CODE_S2440: settle_val = TMR_W'(SETTLE_C_CYC);
            default:        settle_val = TMR_W'(SETTLE_D_CYC);
        endcase
    end

    // Oscillator sequencing
    always_comb
    begin
        osc_nxt     = osc_st_r;
        settle_load = 1'b0;
        case (osc_st_r)
            OSC_OFF:
            begin
                if (osc_code == OSC_CODE_ON)
                    osc_nxt = OSC_ON;
                else if (osc_code != OSC_CODE_OFF && meas_req_i)
                begin
                    osc_nxt     = OSC_SETTLE;
                    settle_load = 1'b1;
                end
            end
            OSC_SETTLE:
            begin
                if (osc_code == OSC_CODE_OFF)
                    osc_nxt = OSC_OFF;
                else if (osc_code == OSC_CODE_ON || settle_done)
                    osc_nxt = OSC_ON;
            end
            OSC_ON:
            begin
                if (osc_code == OSC_CODE_OFF)
                    osc_nxt = OSC_OFF;
                else if (osc_code != OSC_CODE_ON && meas_done_i)
                    osc_nxt = OSC_OFF;
            end
            default: osc_nxt = OSC_OFF;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_st_r    <= OSC_OFF;
            osc_en_o    <= 1'b0;
            osc_ready_o <= 1'b0;
        end
        else
        begin
            osc_st_r    <= osc_nxt;
            osc_en_o    <= osc_nxt != OSC_OFF;
            osc_ready_o <= osc_nxt == OSC_ON;
        end
    end

    tbc_tick_timer u_settle_tmr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (settle_load),
        .load_val_i (settle_val),
        .tick_i     (1'b1),
        .done_o     (settle_done)
    );

    // Resonator calibration window counted in slow clock periods
    assign cal_load = cal_req_i && !cal_busy_o;

    tbc_tick_timer u_cal_tmr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (cal_load),
        .load_val_i (CAL_BASE_PERIODS << cfg.resonator_cal_periods),
        .tick_i     (slow_tick_i),
        .done_o     (cal_done)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cal_busy_o <= 1'b0;
        else if (cal_load)
            cal_busy_o <= 1'b1;
        else if (cal_done)
            cal_busy_o <= 1'b0;
    end

    // ALU and mode controls, plus automatic calibration request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alu_cal_en_o  <= 1'b0;
            second_mode_o <= 1'b0;
            auto_cal_o    <= 1'b0;
        end
        else
        begin
            alu_cal_en_o  <= cfg.alu_calibrate;
            second_mode_o <= cfg.second_mode_select;
            auto_cal_o    <= meas_done_i && !cfg.auto_cal_disable;
        end
    end

    // Edge detect on start and stops, each with its own inversion
    assign edge_in  = {stop_b_i, stop_a_i, start_i};
    assign edge_pol = {cfg.stop_b_polarity, cfg.stop_a_polarity, cfg.start_polarity};

    for (genvar e = 0; e < NUM_EDGES; e++)
    begin : g_edge
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                edge_prev_r[e] <= 1'b1;
                edge_o[e]      <= 1'b0;
            end
            else
            begin
                edge_prev_r[e] <= edge_in[e] ^ edge_pol[e];
                edge_o[e]      <= (edge_in[e] ^ edge_pol[e]) && !edge_prev_r[e];
            end
        end
    end

    // Temperature cycle clock: slow clock or every 128 fast ticks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cyc_cnt_r <= '0;
        else if (fast_tick_i)
            cyc_cnt_r <= cyc_cnt_r + 7'h01;
    end

    assign cycle_tick = cfg.temp_cycle_clock_source ?
                        (fast_tick_i && cyc_cnt_r == CYCLE_DIV_LAST) : slow_tick_i;
    assign tmp_load_val = cfg.temp_cycle_time ? TEMP_LONG_TICKS : TEMP_SHORT_TICKS;
    assign port_idx     = idx_nxt - dummy_nxt;

    // Temperature sequence: dummy cycles first, then one cycle per port
    always_comb
    begin
        tmp_nxt    = tmp_st_r;
        idx_nxt    = idx_r;
        dummy_nxt  = dummy_r;
        ports_nxt  = ports_r;
        tmp_load   = 1'b0;
        sample_nxt = 1'b0;
        done_nxt   = 1'b0;
        case (tmp_st_r)
            TMP_IDLE:
            begin
                if (temp_req_i)
                begin
                    tmp_nxt   = TMP_WAIT;
                    idx_nxt   = '0;
                    dummy_nxt = cfg.temp_dummy_cycles ? DUMMY_MANY : DUMMY_FEW;
                    ports_nxt = cfg.temp_port_count ? PORTS_MANY : PORTS_FEW;
                end
            end
            TMP_WAIT:
            begin
                if (cycle_tick)
                begin
                    tmp_nxt  = TMP_RUN;
                    tmp_load = 1'b1;
                end
            end
            TMP_RUN:
            begin
                if (tmp_tmr_done)
                begin
                    sample_nxt = idx_r >= dummy_r;
                    if (idx_r == dummy_r + ports_r - 4'h1)
                    begin
                        tmp_nxt  = TMP_IDLE;
                        done_nxt = 1'b1;
                    end
                    else
                    begin
                        tmp_nxt = TMP_WAIT;
                        idx_nxt = idx_r + 4'h1;
                    end
                end
            end
            default: tmp_nxt = TMP_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tmp_st_r      <= TMP_IDLE;
            idx_r         <= '0;
            dummy_r       <= '0;
            ports_r       <= '0;
            temp_active_o <= 1'b0;
            temp_dummy_o  <= 1'b0;
            temp_port_o   <= '0;
            temp_sample_o <= 1'b0;
            temp_done_o   <= 1'b0;
        end
        else
        begin
            tmp_st_r      <= tmp_nxt;
            idx_r         <= idx_nxt;
            dummy_r       <= dummy_nxt;
            ports_r       <= ports_nxt;
            temp_active_o <= tmp_nxt != TMP_IDLE;
            temp_dummy_o  <= tmp_nxt != TMP_IDLE && idx_nxt < dummy_nxt;
            temp_port_o   <= (tmp_nxt != TMP_IDLE && idx_nxt >= dummy_nxt) ? port_idx[1:0] : 2'h0;
            temp_sample_o <= sample_nxt;
            temp_done_o   <= done_nxt;
        end
    end

    tbc_tick_timer u_temp_tmr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (tmp_load),
        .load_val_i (tmp_load_val),
        .tick_i     (fast_tick_i),
        .done_o     (tmp_tmr_done)
    );

    // Checks
    logic [3:0] run_cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || (tmp_st_r == TMP_IDLE))
            run_cnt_r <= '0;
        else if (tmp_tmr_done)
            run_cnt_r <= run_cnt_r + 4'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack)
        else $error("request not answered next cycle");
    div_one_a: assert property ((cfg.fast_clock_predivider == 2'h0 && fast_tick_i) |=> fast_div_tick_o)
        else $error("undivided fast tick missing");
    osc_off_a: assert property ((osc_code == OSC_CODE_OFF) |=> !osc_en_o)
        else $error("oscillator on with off code");
    osc_on_a: assert property ((osc_code == OSC_CODE_ON) |=> osc_ready_o)
        else $error("oscillator not on with continuous code");
    start_edge_a: assert property (($stable(cfg_word_r) && (cfg.start_polarity ? $fell(start_i) : $rose(start_i)))
        |=> edge_o[0])
        else $error("start edge missed");
    auto_cal_a: assert property ((meas_done_i && !cfg.auto_cal_disable) |=> auto_cal_o ##1 !auto_cal_o)
        else $error("automatic calibration request wrong");
    alu_cal_a: assert property ($changed(cfg.alu_calibrate) |=> alu_cal_en_o == $past(cfg.alu_calibrate))
        else $error("calibrate control lags");
    mode_sel_a: assert property ($stable(cfg_word_r)[*2] |-> second_mode_o == cfg.second_mode_select)
        else $error("mode output mismatch");
    temp_len_a: assert property (temp_done_o |-> run_cnt_r == dummy_r + ports_r)
        else $error("temperature sequence length wrong");
    cal_busy_a: assert property (cal_load |=> cal_busy_o)
        else $error("calibration window not opened");

    temp_run_c: cover property (temp_req_i && tmp_st_r == TMP_IDLE ##[1:1000] temp_active_o);
    osc_settle_c: cover property (osc_st_r == OSC_SETTLE ##1 osc_st_r == OSC_ON);
    cfg_write_c: cover property (bus_wr && wb_req_i.adr == ADR_CFG);
endmodule : tbc_base_config

// *** verif/tbc_base_config_tb.sv ***
// Self-checking testbench for the base configuration block
module tbc_base_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tbc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    tbc_wb_req_t req   = '0;
    tbc_wb_rsp_t rsp;
    logic        ft    = 1'b0;
    logic [4:0]  pl    = '0; // Pulses: slow, done, cal, temp, meas
    logic [2:0]  ein   = '0;
    logic [2:0]  edges;
    logic        fdt, acal, tsmp, tdone, osc_en, osc_rdy, busy, alu, mode, t_act, t_dum;
    logic [1:0]  t_port;
    logic [1:0]  pm;
    logic [6:0]  mon;
    logic [31:0] q;
    int          errors = 0;
    int          n_compared = 0;
    int          c, c2, c3, c4, k;
    // Second mode only ever written with calibration on
    logic [31:0] rows [3] = '{32'hab00_2000, 32'h5a00_0000, 32'h0000_28c3};
    logic [1:0]  exp_r [3] = '{2'b10, 2'b00, 2'b11};
    int          st [8] = '{0, 0, 10, 20, 30, 40, 40, 40};

    // Clock and monitored pulses
    always #2 clk_i = ~clk_i;
    assign mon = {tdone, tsmp, acal, fdt, edges};

    tbc_base_config #(.SETTLE_A_CYC(10), .SETTLE_B_CYC(20), .SETTLE_C_CYC(30), .SETTLE_D_CYC(40)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .fast_tick_i(ft),
        .slow_tick_i(pl[0]), .meas_done_i(pl[1]), .cal_req_i(pl[2]), .temp_req_i(pl[3]), .meas_req_i(pl[4]),
        .start_i(ein[0]), .stop_a_i(ein[1]), .stop_b_i(ein[2]), .fast_div_tick_o(fdt), .osc_en_o(osc_en),
        .osc_ready_o(osc_rdy), .cal_busy_o(busy), .auto_cal_o(acal), .alu_cal_en_o(alu),
        .second_mode_o(mode), .edge_o(edges), .temp_active_o(t_act), .temp_dummy_o(t_dum),
        .temp_port_o(t_port), .temp_sample_o(tsmp), .temp_done_o(tdone));

    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 40);
        q = rsp.dat;
        req <= '0;
        if (n >= 40)
        begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : wb

    task automatic pulse(input int i);
        @(posedge clk_i);
        pl[i] <= 1'b1;
        @(posedge clk_i);
        pl[i] <= 1'b0;
    endtask : pulse

    task automatic cnt(input int i, input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            c += int'(mon[i]);
        end
    endtask : cnt

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADR_CFG, 0);
        chk(q, CFG_RESET);
        wb(0, ADR_STAT, 0);
        chk(q, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wb(1, ADR_CFG, rows[i]);
            wb(0, ADR_CFG, 0);
            chk(q, rows[i]);
            wb(0, ADR_STAT, 0);
            chk({alu, mode}, exp_r[i]);
            chk(q[7], exp_r[i][1]);
        end
        wb(1, 4'hc, 32'hffff_ffff);
        wb(0, 4'hc, 0);
        chk(q, 32'h0);
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 3; i++)
            begin
                wb(1, ADR_CFG, 32'(p) << (8 + i));
                repeat (3) @(posedge clk_i);
                ein[i] <= 1'b1;
                cnt(i, 4);
                chk(c, 1 - p);
                ein[i] <= 1'b0;
                cnt(i, 4);
                chk(c, p);
            end
        ft <= 1'b1;
        for (int d = 0; d < 4; d++)
        begin
            wb(1, ADR_CFG, 32'(d) << 20);
            repeat (4) @(posedge clk_i);
            cnt(3, 16);
            chk(c, d == 0 ? 16 : d == 1 ? 8 : 4);
        end
        for (int p = 0; p < 2; p++)
        begin
            wb(1, ADR_CFG, 32'(p) << 12);
            pulse(1);
            cnt(4, 4);
            chk(c, 1 - p);
        end
        for (int j = 0; j < 8; j++)
        begin
            wb(1, ADR_EXT, 32'(j / 4) << EXT_OSC_MSB_BIT);
            wb(1, ADR_CFG, 32'(j % 4) << 18);
            if (j < 2)
            begin
                repeat (3) @(posedge clk_i);
                chk({osc_en, osc_rdy}, {2{j[0]}});
            end
            else
            begin
                pulse(1); // Leave continuous-on before settling
                pulse(4);
                repeat (st[j] - 6) @(posedge clk_i);
                chk(osc_rdy, 1'b0);
                repeat (12) @(posedge clk_i);
                chk({osc_en, osc_rdy}, 2'b11);
                pulse(1);
                repeat (3) @(posedge clk_i);
                chk(osc_en, 1'b0);
            end
        end
        for (int d = 0; d < 4; d++)
        begin
            wb(1, ADR_CFG, 32'(d) << 22);
            pulse(2);
            repeat ((2 << d) - 1) pulse(0);
            repeat (2) @(posedge clk_i);
            chk(busy, 1'b1);
            pulse(0);
            repeat (3) @(posedge clk_i);
            chk(busy, 1'b0);
        end
        for (int t = 0; t < 2; t++)
        begin
            wb(1, ADR_CFG, t ? 32'h0003_c000 : 32'h0000_4000);
            pulse(3);
            c = 0;
            c2 = 0;
            c3 = 0;
            c4 = 0;
            pm = '0;
            k = 0;
            // Sample spacing, dummy time, real time and highest port
            do
            begin
                @(posedge clk_i);
                k++;
                if (tsmp === 1'b1 && c2 < 2)
                    c = k - c;
                c2 += int'(tsmp);
                c3 += int'(t_dum);
                c4 += int'(t_act && !t_dum);
                pm |= t_port;
            end
            while (tdone !== 1'b1 && k < 30000);
            if (k >= 30000)
            begin
                chk(32'h0, 32'h1);
                tally_and_finish();
            end
            chk(c2, t ? 4 : 2);
            chk(c, t ? 2176 : 640);
            chk(c4, t ? 8704 : 1280);
            chk(32'(c3 >= (t ? 15106 : 1154) && c3 <= (t ? 15233 : 1281)), 32'h1);
            chk(pm, t ? 2'h3 : 2'h1);
            chk(t_act, 1'b0);
        end
        wb(1, ADR_CFG, 32'hffff_ffff);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADR_CFG, 0);
        chk(q, CFG_RESET);
        chk({alu, mode, osc_en, busy}, 4'h0);
        tally_and_finish();
    end
endmodule : tbc_base_config_tb
